// *** verilog/timer_enable_run_control.sv ***
// enable, run and start control of one 16-bit timer channel
// assumes a wishbone master and synchronous halt, idle and start inputs
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module timer_enable_run_control (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // chip state and triggers
   input wire logic debug_halt_i,
   input wire logic idle_mode_i,
   input wire logic sync_start_i,
   input wire logic external_trigger_input_i,
   // channel outputs
   output logic [15:0] count_o,
   output logic count_active_o,
   output logic double_buffer_enable_o
);
   logic [7:0] enable_reg;
   logic [7:0] run_reg;
   logic [7:0] start_reg;
   logic [timer_ctl_pkg::counter_width-1:0] counter;
   logic [timer_ctl_pkg::prescale_width-1:0] prescale;
   logic started;
   logic trig_edge;
   logic bus_req;
   logic ch_enabled;
   logic low_write;
   logic tick;
   logic clock_gate;
   timer_ctl_pkg::ctl_s ctl;

   // decoded control fields
   always_comb begin
      ctl.module_enable = enable_reg[timer_ctl_pkg::module_enable_bit];
      ctl.debug_halt_stop = enable_reg[timer_ctl_pkg::debug_halt_stop_bit];
      ctl.prescaler_run = run_reg[timer_ctl_pkg::prescaler_run_bit];
      ctl.counter_run = run_reg[timer_ctl_pkg::counter_run_bit];
      ctl.double_buffer_enable =
         start_reg[timer_ctl_pkg::double_buffer_enable_bit];
      ctl.sync_start_mode = start_reg[timer_ctl_pkg::sync_start_mode_bit];
      ctl.idle_operation = start_reg[timer_ctl_pkg::idle_operation_bit];
      ctl.trigger_edge_select =
         start_reg[timer_ctl_pkg::trigger_edge_select_bit];
      ctl.count_start_select =
         start_reg[timer_ctl_pkg::count_start_select_bit];
   end

   // bus request qualifiers; only byte lane 0 holds writable bits
   assign bus_req = cyc_i & stb_i & ~ack_o;
   assign ch_enabled = ctl.module_enable;
   assign low_write = bus_req & we_i & sel_i[0];

   // clock gate as an enable: halt stops it with halt stop set, idle with idle operation clear; disable stops all
   assign clock_gate = ch_enabled
      & ~(debug_halt_i & ctl.debug_halt_stop)
      & ~(idle_mode_i & ~ctl.idle_operation);

   // enable register, always reachable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_reg <= timer_ctl_pkg::reg_reset;
      end else if (low_write && adr_i == timer_ctl_pkg::enable_offset) begin
         enable_reg <= dat_i[7:0] & timer_ctl_pkg::enable_mask;
      end
   end

   // run register; writes blocked while disabled, value kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_reg <= timer_ctl_pkg::reg_reset;
      end else if (low_write && ch_enabled
                   && adr_i == timer_ctl_pkg::run_offset) begin
         run_reg <= dat_i[7:0] & timer_ctl_pkg::run_mask;
      end
   end

   // start control register; software is expected to stop first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_reg <= timer_ctl_pkg::reg_reset;
      end else if (low_write && ch_enabled
                   && adr_i == timer_ctl_pkg::start_offset) begin
         start_reg <= dat_i[7:0] & timer_ctl_pkg::start_mask;
      end
   end

   // external trigger edge
   trigger_edge_detect edge_unit (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(external_trigger_input_i),
      .falling_i(ctl.trigger_edge_select),
      .edge_o(trig_edge)
   );

   // start latch: software, sync or trigger; cleared by counter stop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         started <= 1'h0;
      end else if (clock_gate) begin
         if (!ctl.counter_run) begin
            started <= 1'h0;
         end else if (ctl.count_start_select) begin
            if (trig_edge) begin
               started <= 1'h1;
            end
         end else if (ctl.sync_start_mode) begin
            if (sync_start_i) begin
               started <= 1'h1;
            end
         end else begin
            started <= 1'h1;
         end
      end
   end

   // prescaler; the tick is its terminal count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prescale <= '0;
      end else if (clock_gate) begin
         if (!ctl.prescaler_run) begin
            prescale <= '0;
         end else begin
            prescale <= prescale + 8'h01;
         end
      end
   end
   assign tick = ctl.prescaler_run & (&prescale);

   // 16-bit up-counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter <= '0;
      end else if (clock_gate) begin
         if (!ctl.counter_run) begin
            counter <= '0;
         end else if (started && tick) begin
            counter <= counter + 16'h0001;
         end
      end
   end

   // bus answer: one cycle after the request, dropped next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'h0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         dat_o <= 32'h0000_0000;
         if (bus_req && !we_i) begin
            case (adr_i)
               timer_ctl_pkg::enable_offset: begin
                  dat_o <= {24'h000000, enable_reg};
               end
               timer_ctl_pkg::run_offset: begin
                  if (ch_enabled) begin
                     dat_o <= {24'h000000, run_reg};
                  end
               end
               timer_ctl_pkg::start_offset: begin
                  if (ch_enabled) begin
                     dat_o <= {24'h000000, start_reg};
                  end
               end
               timer_ctl_pkg::count_offset: begin
                  if (ch_enabled) begin
                     dat_o <= {16'h0000, counter};
                  end
               end
               timer_ctl_pkg::prescale_offset: begin
                  if (ch_enabled) begin
                     dat_o <= {24'h000000, prescale};
                  end
               end
               default: begin
                  dat_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // registered outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= 16'h0000;
         count_active_o <= 1'h0;
         double_buffer_enable_o <= 1'h0;
      end else begin
         count_o <= counter;
         count_active_o <= started & clock_gate;
         double_buffer_enable_o <= ctl.double_buffer_enable;
      end
   end
endmodule

// *** verilog/timer_ctl_pkg.sv ***
// constants, field layouts and carrier structs of the timer control front end
// assumes a classic wishbone slave with 32-bit data and byte addressing
// Behaviour
// - module enable bit 7 at 0 stops the clock to all other registers.
// - while disabled, only the enable register is reachable from the bus.
// - disabling after enabling keeps every programmed value.
// - halt stop bit 6 runs the clock in debug halt at 0, stops it at 1.
// - prescaler run bit 2 stops and clears the prescaler at 0, counts at 1.
// - counter run bit 0 stops and clears the up-counter at 0, counts at 1.
// - control bit 7 disables compare double buffering at 0, enables it at 1.
// - sync start bit 5 runs the channel alone at 0, on the common start at 1.
// - idle bit 3 stops the timer in idle mode at 0, keeps it running at 1.
// - trigger edge bit 1 picks the rising edge at 0 and the falling at 1.
// - count start bit 0 starts by software at 0, on the trigger edge at 1.
// - the counter is a 16-bit up-counter.
package timer_ctl_pkg;
   localparam logic [7:0] enable_offset = 8'h00;
   localparam logic [7:0] run_offset = 8'h04;
   localparam logic [7:0] start_offset = 8'h08;
   localparam logic [7:0] count_offset = 8'h0C;
   localparam logic [7:0] prescale_offset = 8'h10;
   localparam int module_enable_bit = 7;
   localparam int debug_halt_stop_bit = 6;
   localparam int prescaler_run_bit = 2;
   localparam int counter_run_bit = 0;
   localparam int double_buffer_enable_bit = 7;
   localparam int sync_start_mode_bit = 5;
   localparam int idle_operation_bit = 3;
   localparam int trigger_edge_select_bit = 1;
   localparam int count_start_select_bit = 0;
   localparam logic [7:0] enable_mask = 8'hC0;
   localparam logic [7:0] run_mask = 8'h05;
   localparam logic [7:0] start_mask = 8'hAB;
   localparam logic [7:0] reg_reset = 8'h00;
   localparam int counter_width = 16;
   localparam int prescale_width = 8;
   typedef struct packed {
      logic module_enable;
      logic debug_halt_stop;
      logic prescaler_run;
      logic counter_run;
      logic double_buffer_enable;
      logic sync_start_mode;
      logic idle_operation;
      logic trigger_edge_select;
      logic count_start_select;
   } ctl_s;
endpackage

// *** verilog/trigger_edge_detect.sv ***
// edge detector for the external trigger input of the timer channel
// assumes the input is already synchronous to clk_i
`timescale 1ns/1ps
module trigger_edge_detect (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // trigger
   input wire logic level_i,
   input wire logic falling_i,
   output logic edge_o
);
   logic last;
   // previous level of the pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last <= 1'h0;
      end else begin
         last <= level_i;
      end
   end
   // selected edge
   always_comb begin
      if (falling_i) begin
         edge_o = last & ~level_i;
      end else begin
         edge_o = ~last & level_i;
      end
   end
endmodule

// *** testbench/timer_ctl_monitor.sv ***
// bus and count checks of the timer control front end
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module timer_ctl_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // channel
   input wire logic [15:0] count_o,
   input wire logic count_active_o,
   input wire logic double_buffer_enable_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // request taken, then a one-cycle answer
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_ans; ack_o ##1 !ack_o; endsequence
   property p_ack; s_req |=> s_ans; endproperty
   property p_src; ack_o |-> $past(cyc_i && stb_i); endproperty
   property p_idle; !ack_o |-> dat_o == 32'h0; endproperty
   // only the counter readback has live bits above the low byte
   property p_upper;
      ack_o |-> dat_o[31:16] == 16'h0000 && (dat_o[15:8] == 8'h00 ||
         $past(adr_i) == timer_ctl_pkg::count_offset);
   endproperty
   // only a bus write may move the buffer flag
   property p_dbe;
      $changed(double_buffer_enable_o) |->
         $past(cyc_i && stb_i && we_i) || $past(cyc_i && stb_i && we_i, 2);
   endproperty
   // steps of one, or a clear, never a jump
   property p_step;
      ##1 (count_o == $past(count_o) || count_o == 16'h0 ||
         count_o == $past(count_o) + 16'h1);
   endproperty
   // an advance needs an open gate shortly before
   property p_cause;
      count_o != $past(count_o) && count_o != 16'h0 |->
         $past(count_active_o) || $past(count_active_o, 2) ||
         $past(count_active_o, 3);
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a pulse");
   a_src: assert property (p_src) else $error("ack without request");
   a_idle: assert property (p_idle) else $error("data outside ack");
   a_upper: assert property (p_upper) else $error("upper bits set");
   a_dbe: assert property (p_dbe) else $error("buffer flag moved");
   a_step: assert property (p_step) else $error("count jumped");
   a_cause: assert property (p_cause) else $error("count while off");
endmodule
bind timer_enable_run_control timer_ctl_monitor timer_ctl_monitor_i (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .count_o(count_o),
   .count_active_o(count_active_o),
   .double_buffer_enable_o(double_buffer_enable_o));

// *** testbench/tb_timer_enable_run_control.sv ***
// self-checking bench of the timer control front end
// assumes a one-cycle wishbone answer from the design
`timescale 1ns/1ps
module tb_timer_enable_run_control;
   logic clk_i = 1'h0, rst_i = 1'h1, cs = 1'h0, we = 1'h0;
   logic halt = 1'h0, idle = 1'h0, sync = 1'h0, pin = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, dat_o, r;
   logic ack_o, act, dbe;
   logic [15:0] count_o;
   int n_mismatch = 0, n_checks = 0;
   timer_enable_run_control timer_enable_run_control_i (.clk_i(clk_i),
      .rst_i(rst_i), .cyc_i(cs), .stb_i(cs), .we_i(we), .adr_i(adr),
      .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
      .debug_halt_i(halt), .idle_mode_i(idle), .sync_start_i(sync),
      .external_trigger_input_i(pin), .count_o(count_o),
      .count_active_o(act), .double_buffer_enable_o(dbe));
   // free running clock
   initial forever #5 clk_i = ~clk_i;
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask
   // one classic cycle, held until ack is sampled
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      adr <= a; dat <= d; we <= w; cs <= 1'h1;
      i = 0;
      do begin @(posedge clk_i); i++; end while (ack_o !== 1'h1 && i < 20);
      if (ack_o !== 1'h1) begin n_mismatch++; close_out(); end
      r = dat_o;
      cs <= 1'h0;
      @(posedge clk_i);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d); bus(1'h1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(r, e);
   endtask
   task wact(input logic e);
      int i;
      for (i = 0; i < 600 && act !== e; i++) @(posedge clk_i);
      chk(act, e);
      if (act !== e) close_out();
   endtask
   // restart the counter in a new start mode, stopped first
   task mode(input logic [7:0] c);
      wr(8'h04, 32'h0); wr(8'h08, {24'h0, c}); wr(8'h04, 32'h5);
      repeat (3) @(posedge clk_i);
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      for (int a = 0; a < 12; a += 4) rd(a[7:0], 32'h0);
      wr(8'h04, 32'hFF); rd(8'h04, 32'h0);
      wr(8'h00, 32'hFFFFFFFF); rd(8'h00, 32'hC0);
      rd(8'h04, 32'h0);
      wr(8'h08, 32'hFF); rd(8'h08, 32'hAB);
      chk(dbe, 1'h1);
      wr(8'h04, 32'hFF); rd(8'h04, 32'h5);
      chk(act, 1'h0);
      rd(8'h20, 32'h0);
      wr(8'h00, 32'h40); rd(8'h08, 32'h0);
      wr(8'h00, 32'hC0); rd(8'h08, 32'hAB);
      rd(8'h04, 32'h5);
      $display("test done: registers");
      wr(8'h04, 32'h0); rd(8'h0C, 32'h0);
      mode(8'h00); chk(dbe, 1'h0);
      wact(1'h1);
      repeat (600) @(posedge clk_i);
      bus(1'h0, 8'h0C, 32'h0); chk(r != 0, 1'h1);
      wr(8'h04, 32'h4); rd(8'h0C, 32'h0); chk(count_o, 16'h0000);
      wr(8'h04, 32'h5);
      halt <= 1'h1; repeat (3) @(posedge clk_i); chk(act, 1'h0);
      halt <= 1'h0; wact(1'h1); wr(8'h00, 32'h80);
      halt <= 1'h1; repeat (3) @(posedge clk_i); chk(act, 1'h1);
      halt <= 1'h0; idle <= 1'h1; wact(1'h0);
      idle <= 1'h0; mode(8'h08); idle <= 1'h1; wact(1'h1);
      idle <= 1'h0; wr(8'h04, 32'h1); rd(8'h10, 32'h0);
      bus(1'h0, 8'h0C, 32'h0); chk(r, 32'h0);
      $display("test done: gating");
      for (int e = 0; e < 2; e++) begin
         pin <= !e[0];
         mode({6'h00, e[0], 1'h1});
         pin <= e[0]; repeat (3) @(posedge clk_i); chk(act, 1'h0);
         pin <= !e[0]; wact(1'h1);
      end
      mode(8'h20); chk(act, 1'h0);
      sync <= 1'h1; wact(1'h1);
      sync <= 1'h0; wr(8'h00, 32'h0); wact(1'h0);
      $display("test done: start modes");
      close_out();
   end
endmodule
